// [caf_pkg.sv]
/*
  caf_pkg: shared constants for the clock alarm flag and calibration register group.
  Assumes: single 100 MHz clock, synchronous active-low reset, 8-bit register port.
*/
`default_nettype none
package caf_pkg;
  // register offsets
  localparam logic [7:0] CAF_OFS_LOS_FLAGS  = 8'h83;
  localparam logic [7:0] CAF_OFS_FOS_FLAGS  = 8'h84;
  localparam logic [7:0] CAF_OFS_PART_HIGH  = 8'h86;
  localparam logic [7:0] CAF_OFS_PART_LOW   = 8'h87;
  localparam logic [7:0] CAF_OFS_CTRL       = 8'h88;
  // host command port registers
  localparam logic [3:0] CAF_HOFS_CMD       = 4'h0;
  localparam logic [3:0] CAF_HOFS_STATUS    = 4'h1;
  localparam logic [3:0] CAF_HOFS_MASK      = 4'h2;
  localparam logic [3:0] CAF_HOFS_DEV_ADDR  = 4'h3;
  localparam logic [3:0] CAF_HOFS_DEV_WDATA = 4'h4;
  localparam logic [3:0] CAF_HOFS_DEV_RDATA = 4'h5;
  // field positions
  localparam int CAF_LOS2_BIT  = 2;
  localparam int CAF_LOS1_BIT  = 1;
  localparam int CAF_LOSX_BIT  = 0;
  localparam int CAF_FOS2_BIT  = 3;
  localparam int CAF_FOS1_BIT  = 2;
  localparam int CAF_LOL_BIT   = 1;
  localparam int CAF_SRST_BIT  = 7;
  localparam int CAF_SELF_CALIBRATION_START_BIT  = 6;
  // writable-flag layouts; other bits are reserved and read zero
  localparam logic [7:0] CAF_LOS_FLAG_MASK = 8'h07;
  localparam logic [7:0] CAF_FOS_FLAG_MASK = 8'h0E;
  // reset values
  localparam logic [7:0] CAF_RST_FLAGS     = 8'h00;
  localparam logic [7:0] CAF_RST_MASKS     = 8'h00;
  localparam logic [7:0] CAF_RST_BYTE      = 8'h00;
  // timing
  localparam int CAF_CLK_MHZ          = 100;
  localparam int CAF_SRST_QUIET_MS    = 10;
  localparam int CAF_SRST_QUIET_CYC   = CAF_SRST_QUIET_MS * 1000 * CAF_CLK_MHZ;
  localparam int CAF_SRST_PULSE_CYC   = 4;
  // host command codes
  localparam logic [1:0] CAF_CMD_WRITE = 2'h1;
  localparam logic [1:0] CAF_CMD_READ  = 2'h2;
endpackage
`default_nettype wire

// [caf_link_if.sv]
/*
  caf_link_if: register access link between host controller and device register group.
  Assumes: both ends share clock_i; one access a cycle, read data one cycle later.
*/
`default_nettype none
interface caf_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq;
  logic       in_reset;
  modport host   (output addr, output wdata, output wr, output rd,
                  input rdata, input irq, input in_reset);
  modport device (input addr, input wdata, input wr, input rd,
                  output rdata, output irq, output in_reset);
endinterface
`default_nettype wire

// [caf_sync2.sv]
/*
  caf_sync2: two-flop synchroniser for a vector of pin levels.
  Assumes: inputs asynchronous to clock_i.
*/
`default_nettype none
module caf_sync2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } caf_sync_s;
  caf_sync_s state_ff;
  caf_sync_s nxt_state;
  // first stage feeds only the second
  always_comb
  begin
    nxt_state.meta = async_i;
    nxt_state.sync = state_ff.meta;
  end
  // register the pair
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end
  assign sync_o = state_ff.sync;
endmodule
`default_nettype wire

// [caf_device.sv]
/*
  caf_device: alarm sticky flags, identification and reset/calibration control register group.
  Assumes: live alarm levels arrive from detectors on another clock and are synchronised here;
  the host obeys the soft reset quiet time and calibration preconditions.
  The large-shift indication also comes from the detectors and is synchronised with them.
  Mask and interrupt enable are configuration levels on this clock and are used directly.
  Register accesses stay legal during the reset stretch; only the clock outputs are held off.
*/
// Implementation choice: the plain strobed port.
`default_nettype none
// How it works
// (RULE1) sticky signal-loss flags in bits 2,1,0
// (RULE2) sticky offset and unlock flags bits 3,2,1
// (RULE3) interrupt when unmasked flag set and enabled
// (RULE4) mask gates interrupt; flag still latches
// (RULE5) flag cleared only by writing zero
// (RULE6) writing one keeps flag; reserved read zero
// (RULE7) soft reset bit resets like pin
// (RULE8) clock outputs disabled during internal reset
// (RULE9) host waits 10 ms after soft reset
// (RULE10) calibration bit starts cal, self-clears
// (RULE11) calibration done shown by unlock deasserting
// (RULE12) host calibrates at start and after changes
// (RULE13) host calibrates only with stable input clock
// (RULE14) device may self-calibrate on big shift
// (RULE15) identification read-only, constant, ignores writes
// (RULE16) live signal-loss alarm high while lost
// (RULE17) live unlock alarm high while unlocked
module caf_device
  import caf_pkg::*;
#(
  parameter logic [11:0] PART_NUMBER = 12'h5A5, // arbitrary value
  parameter logic [3:0]  REVISION    = 4'h7     // arbitrary value
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  caf_link_if.device      link,
  input  wire logic       input2_signal_loss_live_i,
  input  wire logic       input1_signal_loss_live_i,
  input  wire logic       crystal_ref_signal_loss_live_i,
  input  wire logic       input2_freq_offset_live_i,
  input  wire logic       input1_freq_offset_live_i,
  input  wire logic       pll_unlock_live_i,
  input  wire logic       freq_shift_large_i,
  input  wire logic       int_pin_enable_i,
  input  wire logic [5:0] flag_mask_i,
  output logic            self_calibration_start_o,
  output logic            clock_outputs_enable_o,
  output logic            interrupt_o
);
  typedef struct packed {
    logic [7:0] los_flags;
    logic [7:0] fos_flags;
    logic [7:0] rdata;
    logic       cal_pulse;
    logic [2:0] srst_cnt;
    logic       in_reset;
    logic       shift_seen;
  } caf_dev_s;
  caf_dev_s   state_ff;
  caf_dev_s   nxt_state;
  logic [6:0] live_sync;
  logic [7:0] los_live;
  logic [7:0] fos_live;
  logic       shift_sync;
  logic       los_wr_hit;
  logic       fos_wr_hit;
  logic       ctrl_wr_hit;
  logic       soft_rst;
  logic       sync_rst_n;
  logic [5:0] flag_vector;

  // true when a write strobe targets the given offset
  function automatic logic write_hits(
    input logic       wr,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return wr && (addr == ofs);
  endfunction

  // next value of one sticky flag byte: a written zero clears a flag,
  // a written one leaves it alone and reserved positions stay zero;
  // a live alarm sets its flag even in the cycle of a clear, so an
  // alarm that rises while software acknowledges the old one is never lost
  function automatic logic [7:0] sticky_next(
    input logic [7:0] flags,
    input logic       hit,
    input logic [7:0] wdata,
    input logic [7:0] live,
    input logic [7:0] layout
  );
    logic [7:0] kept;
    kept = flags & layout;
    if (hit)
      kept = kept & wdata; // [RULE5] [RULE6]
    return kept | (live & layout);
  endfunction

  // read-back byte for one offset; unmapped offsets read zero
  function automatic logic [7:0] read_back(
    input logic [7:0] addr,
    input logic [7:0] los_flags,
    input logic [7:0] fos_flags
  );
    logic [7:0] value;
    value = CAF_RST_BYTE;
    unique case (addr)
      CAF_OFS_LOS_FLAGS: value = los_flags & CAF_LOS_FLAG_MASK; // [RULE6]
      CAF_OFS_FOS_FLAGS: value = fos_flags & CAF_FOS_FLAG_MASK; // [RULE6]
      CAF_OFS_PART_HIGH: value = PART_NUMBER[11:4];             // [RULE15]
      CAF_OFS_PART_LOW:  value = {PART_NUMBER[3:0], REVISION};  // [RULE15]
      default:           value = CAF_RST_BYTE;                  // control bits self-clear and read zero
    endcase
    return value;
  endfunction

  // detector levels and the shift indication come from another clock;
  // a soft reset clears the synchroniser too, like the pin does
  assign sync_rst_n = rst_n_i && !soft_rst; // [RULE7]
  caf_sync2 #(.WIDTH(7)) u_sync (
    .clock_i (clock_i),
    .rst_n_i (sync_rst_n),
    .async_i ({freq_shift_large_i, input2_signal_loss_live_i, input1_signal_loss_live_i,
               crystal_ref_signal_loss_live_i, input2_freq_offset_live_i, input1_freq_offset_live_i,
               pll_unlock_live_i}),
    .sync_o  (live_sync)
  );
  assign shift_sync = live_sync[6];

  // live alarms placed in flag layout, high means alarm present
  always_comb
  begin
    los_live = '0;
    fos_live = '0;
    los_live[CAF_LOS2_BIT] = live_sync[5]; // [RULE16]
    los_live[CAF_LOS1_BIT] = live_sync[4]; // [RULE16]
    los_live[CAF_LOSX_BIT] = live_sync[3]; // [RULE16]
    fos_live[CAF_FOS2_BIT] = live_sync[2];
    fos_live[CAF_FOS1_BIT] = live_sync[1];
    // the unlock flag follows the live alarm, whose drop marks calibration done
    fos_live[CAF_LOL_BIT]  = live_sync[0]; // [RULE17] [RULE11]
  end

  // write decode for the writable offsets
  assign los_wr_hit  = write_hits(link.wr, link.addr, CAF_OFS_LOS_FLAGS);
  assign fos_wr_hit  = write_hits(link.wr, link.addr, CAF_OFS_FOS_FLAGS);
  assign ctrl_wr_hit = write_hits(link.wr, link.addr, CAF_OFS_CTRL);
  // soft reset write acts like the reset pin; it wins over a calibration
  // start written in the same byte
  assign soft_rst    = ctrl_wr_hit && link.wdata[CAF_SRST_BIT]; // [RULE7]

  // next state: sticky flags, reads, calibration and reset stretch
  always_comb
  begin
    nxt_state           = state_ff;
    nxt_state.cal_pulse = 1'b0;
    nxt_state.rdata     = CAF_RST_BYTE;
    // reset stretch counts down; in_reset drops with the last count
    if (state_ff.srst_cnt != '0)
      nxt_state.srst_cnt = state_ff.srst_cnt - 3'd1;
    nxt_state.in_reset = (state_ff.srst_cnt > 3'd1);
    // sticky flags: zero written clears, ones keep, set wins over clear
    nxt_state.los_flags = sticky_next(state_ff.los_flags, los_wr_hit, link.wdata,
                                      los_live, CAF_LOS_FLAG_MASK); // [RULE1]
    nxt_state.fos_flags = sticky_next(state_ff.fos_flags, fos_wr_hit, link.wdata,
                                      fos_live, CAF_FOS_FLAG_MASK); // [RULE2]
    // calibration start is a one-cycle pulse, the bit never holds
    if (ctrl_wr_hit && link.wdata[CAF_SELF_CALIBRATION_START_BIT])
      nxt_state.cal_pulse = 1'b1; // [RULE10]
    // autonomous calibration on the rising edge of a large input shift
    nxt_state.shift_seen = shift_sync;
    if (shift_sync && !state_ff.shift_seen)
      nxt_state.cal_pulse = 1'b1; // [RULE14]
    // read data stands only in the cycle after the strobe and is zero
    // otherwise, so a late sample by the host never picks up stale flags
    if (link.rd)
      nxt_state.rdata = read_back(link.addr, state_ff.los_flags, state_ff.fos_flags);
  end

  // pin or soft reset restores everything, either reset stretched a few cycles;
  // the stretch keeps the clock outputs off long enough for downstream
  // logic to see a clean stop, whichever reset started it
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || soft_rst) // [RULE7]
    begin
      state_ff            <= '0;
      state_ff.srst_cnt   <= 3'(CAF_SRST_PULSE_CYC);
      state_ff.in_reset   <= 1'b1;
    end
    else
      state_ff <= nxt_state;
  end

  // outputs
  assign link.rdata               = state_ff.rdata;
  assign link.in_reset            = state_ff.in_reset;
  assign self_calibration_start_o = state_ff.cal_pulse;
  assign clock_outputs_enable_o   = !state_ff.in_reset; // [RULE8]
  // flags gathered in mask order {los2, los1, losx, fos2, fos1, lol}
  assign flag_vector = {state_ff.los_flags[CAF_LOS2_BIT], state_ff.los_flags[CAF_LOS1_BIT],
                        state_ff.los_flags[CAF_LOSX_BIT], state_ff.fos_flags[CAF_FOS2_BIT],
                        state_ff.fos_flags[CAF_FOS1_BIT], state_ff.fos_flags[CAF_LOL_BIT]};
  // interrupt is a level: any set flag whose mask is clear, only while the
  // pin function is enabled; a masked flag still latches and shows on read
  assign interrupt_o = int_pin_enable_i && |(flag_vector & ~flag_mask_i); // [RULE3] [RULE4]
  assign link.irq    = interrupt_o;
endmodule
`default_nettype wire

// [caf_host.sv]
/*
  caf_host: host controller issuing register accesses to the alarm register group.
  Assumes: software drives a plain port; read data one cycle after a read strobe.
*/
`default_nettype none
module caf_host
  import caf_pkg::*;
#(
  parameter int QUIET_CYC = CAF_SRST_QUIET_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  caf_link_if.host        link,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            interrupt_o
);
  typedef struct packed {
    logic [7:0]  dev_addr;
    logic [7:0]  dev_wdata;
    logic [7:0]  dev_rdata;
    logic [1:0]  status;   // bit0 done, bit1 refused
    logic [1:0]  mask;
    logic [31:0] quiet;
    logic        dwr;
    logic        drd;
    logic        capture;
    logic [7:0]  rdata;
  } caf_host_s;
  caf_host_s state_ff;
  caf_host_s nxt_state;
  logic      busy;

  assign busy = (state_ff.quiet != '0);

  // command decode, quiet time after soft reset, status and reads
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.dwr = 1'b0;
    nxt_state.drd = 1'b0;
    nxt_state.capture = state_ff.drd;
    nxt_state.rdata = '0;
    if (busy)
      nxt_state.quiet = state_ff.quiet - 32'd1; // [RULE9]
    // a status read clears what it shows; any set below in this cycle wins
    if (rd_i && addr_i == CAF_HOFS_STATUS)
      nxt_state.status = '0;
    if (state_ff.capture)
    begin
      nxt_state.dev_rdata = link.rdata;
      nxt_state.status[0] = 1'b1;
    end
    if (wr_i)
    begin
      unique case (addr_i)
        CAF_HOFS_DEV_ADDR:  nxt_state.dev_addr = wdata_i;
        CAF_HOFS_DEV_WDATA: nxt_state.dev_wdata = wdata_i;
        CAF_HOFS_MASK:      nxt_state.mask = wdata_i[1:0];
        CAF_HOFS_CMD:
        begin
          if (busy)
            nxt_state.status[1] = 1'b1; // [RULE9]
          else if (wdata_i[1:0] == CAF_CMD_WRITE)
          begin
            nxt_state.dwr = 1'b1;
            nxt_state.status[0] = 1'b1;
            if (state_ff.dev_addr == CAF_OFS_CTRL && state_ff.dev_wdata[CAF_SRST_BIT])
              nxt_state.quiet = 32'(QUIET_CYC); // [RULE9]
          end
          else if (wdata_i[1:0] == CAF_CMD_READ)
            nxt_state.drd = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        CAF_HOFS_STATUS:    nxt_state.rdata = {6'd0, state_ff.status};
        CAF_HOFS_MASK:      nxt_state.rdata = {6'd0, state_ff.mask};
        CAF_HOFS_DEV_ADDR:  nxt_state.rdata = state_ff.dev_addr;
        CAF_HOFS_DEV_WDATA: nxt_state.rdata = state_ff.dev_wdata;
        CAF_HOFS_DEV_RDATA: nxt_state.rdata = state_ff.dev_rdata;
        default:            nxt_state.rdata = {7'd0, busy};
      endcase
    end
  end

  // register the state
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // link drive
  assign link.addr   = state_ff.dev_addr;
  assign link.wdata  = state_ff.dev_wdata;
  assign link.wr     = state_ff.dwr;
  assign link.rd     = state_ff.drd;
  assign rdata_o     = state_ff.rdata;
  assign interrupt_o = |(state_ff.status & ~state_ff.mask) | link.irq;
endmodule
`default_nettype wire

// [caf_sva.sv]
/*
  caf_sva: checks on the register link between host and device ends.
  Assumes: one clock, rst_n_i synchronous active low, ID values as passed in.
*/
`default_nettype none
module caf_sva #(
  parameter logic [11:0] PART_NUMBER = 12'h5A5,
  parameter logic [3:0]  REVISION    = 4'h7
) (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       in_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  import caf_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // read request aimed at one offset
  sequence s_rd(logic [7:0] a);
    rd && addr == a;
  endsequence
  // soft reset write
  sequence s_srst;
    wr && addr == CAF_OFS_CTRL && wdata[CAF_SRST_BIT];
  endsequence
  property p_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_ctrl;
    s_rd(CAF_OFS_CTRL) |=> rdata == 8'h00;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control bits did not clear");
  property p_idh;
    s_rd(CAF_OFS_PART_HIGH) |=> rdata == PART_NUMBER[11:4];
  endproperty
  a_idh: assert property (p_idh) else $error("part number high wrong");
  property p_idl;
    s_rd(CAF_OFS_PART_LOW) |=> rdata == {PART_NUMBER[3:0], REVISION};
  endproperty
  a_idl: assert property (p_idl) else $error("part number low wrong");
  property p_los;
    s_rd(CAF_OFS_LOS_FLAGS) |=> (rdata & ~CAF_LOS_FLAG_MASK) == 8'h00;
  endproperty
  a_los: assert property (p_los) else $error("reserved loss bits set");
  property p_fos;
    s_rd(CAF_OFS_FOS_FLAGS) |=> (rdata & ~CAF_FOS_FLAG_MASK) == 8'h00;
  endproperty
  a_fos: assert property (p_fos) else $error("reserved offset bits set");
  property p_srst;
    s_srst |-> ##[1:2] in_reset;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset not taken");
  property p_stretch;
    in_reset |-> ##[1:8] !in_reset;
  endproperty
  a_stretch: assert property (p_stretch) else $error("reset stretch too long");
  property p_irq_srst;
    s_srst |=> !irq;
  endproperty
  a_irq_srst: assert property (p_irq_srst) else $error("interrupt survived soft reset");
endmodule
`default_nettype wire

// [testbench.sv]
/*
  testbench: host and device ends joined by the link, driven from the host port.
  Assumes: caf_pkg, caf_link_if, caf_host, caf_device, caf_sva compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import caf_pkg::*;
  localparam logic [11:0] PN = 12'h5A5; // arbitrary value
  localparam logic [3:0]  RV = 4'h7;    // arbitrary value
  localparam int          QC = 20;
  logic        clock_i, rst_n_i, wr_i, rd_i, fshift, ien, cal_o, cken_o, dev_irq, host_irq;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o;
  logic [5:0]  al, msk;
  logic [31:0] seed;
  int          mismatches, check_count;
  caf_link_if link();
  caf_device #(.PART_NUMBER(PN), .REVISION(RV)) i_caf_device (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .link(link), .input2_signal_loss_live_i(al[5]), .input1_signal_loss_live_i(al[4]),
    .crystal_ref_signal_loss_live_i(al[3]), .input2_freq_offset_live_i(al[2]),
    .input1_freq_offset_live_i(al[1]), .pll_unlock_live_i(al[0]), .freq_shift_large_i(fshift),
    .int_pin_enable_i(ien), .flag_mask_i(msk), .self_calibration_start_o(cal_o),
    .clock_outputs_enable_o(cken_o), .interrupt_o(dev_irq));
  caf_host #(.QUIET_CYC(QC)) i_caf_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .interrupt_o(host_irq));
  caf_sva #(.PART_NUMBER(PN), .REVISION(RV)) i_caf_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .irq(link.irq), .in_reset(link.in_reset));
  // xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // host port cycles
  task automatic hwr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic hrd(input logic [3:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clock_i);
  endtask
  // device register access through the host command registers
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    hwr(CAF_HOFS_DEV_ADDR, a);
    hwr(CAF_HOFS_DEV_WDATA, d);
    hwr(CAF_HOFS_CMD, {6'h00, CAF_CMD_WRITE});
  endtask
  task automatic drd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] s;
    hwr(CAF_HOFS_DEV_ADDR, a);
    hrd(CAF_HOFS_STATUS, s); // drop a done bit left by an earlier command
    hwr(CAF_HOFS_CMD, {6'h00, CAF_CMD_READ});
    s = 8'h00;
    for (int i = 0; i < 20 && s[0] !== 1'b1; i++)
      hrd(CAF_HOFS_STATUS, s);
    if (s[0] !== 1'b1)
    begin
      mismatches++;
      finish_test();
    end
    hrd(CAF_HOFS_DEV_RDATA, d);
  endtask
  // bounded wait for a calibration pulse
  task automatic wait_cal();
    int i;
    #1; // look after the edge that launches the pulse
    for (i = 0; i < 10 && cal_o !== 1'b1; i++)
      @(posedge clock_i) #1;
    if (i == 10)
    begin
      mismatches++;
      finish_test();
    end
  endtask
  // clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // main sequence
  initial
  begin
    logic [7:0] d, r;
    logic [5:0] a, m;
    logic       e;
    {rst_n_i, wr_i, rd_i, fshift, ien, addr_i, wdata_i, al, msk} = '0;
    seed = 32'h0000_0056;
    repeat (2) @(posedge clock_i);
    #1 chk({7'h00, cken_o}, 8'h00);
    rst_n_i <= 1'b1;
    dwr(CAF_OFS_PART_HIGH, 8'hFF);
    drd(CAF_OFS_PART_HIGH, d);
    chk(d, PN[11:4]);
    drd(CAF_OFS_PART_LOW, d);
    chk(d, {PN[3:0], RV});
    drd(8'h85, d);
    chk(d, 8'h00);
    // random alarm patterns, all-set corner first
    for (int n = 0; n < 8; n++)
    begin
      r = rnd();
      a = (n == 0) ? 6'h3F : r[5:0];
      al <= a;
      repeat (4) @(posedge clock_i);
      al <= 6'h00;
      r = rnd();
      m = (n == 0) ? 6'h00 : r[5:0];
      e = (n == 0) ? 1'b1 : r[6];
      msk <= m;
      ien <= e;
      repeat (4) @(posedge clock_i);
      #1 chk({7'h00, dev_irq}, {7'h00, e & |(a & ~m)});
      dwr(CAF_OFS_LOS_FLAGS, 8'hFF);
      drd(CAF_OFS_LOS_FLAGS, d);
      chk(d, {5'h00, a[5:3]});
      r = rnd();
      dwr(CAF_OFS_FOS_FLAGS, r);
      drd(CAF_OFS_FOS_FLAGS, d);
      chk(d, {4'h0, a[2:0], 1'b0} & r);
      dwr(CAF_OFS_LOS_FLAGS, 8'h00);
      dwr(CAF_OFS_FOS_FLAGS, 8'h00);
      #1 chk({7'h00, dev_irq}, 8'h00);
    end
    dwr(CAF_OFS_CTRL, 8'h40);
    wait_cal();
    drd(CAF_OFS_CTRL, d);
    chk(d, 8'h00);
    fshift <= 1'b1;
    wait_cal();
    fshift <= 1'b0;
    // soft reset clears a latched flag; commands refused meanwhile
    al <= 6'h01;
    repeat (4) @(posedge clock_i);
    al <= 6'h00;
    dwr(CAF_OFS_CTRL, 8'h80);
    hwr(CAF_HOFS_CMD, {6'h00, CAF_CMD_READ});
    #1 chk({7'h00, cken_o}, 8'h00);
    chk({7'h00, host_irq}, 8'h01);
    hwr(CAF_HOFS_MASK, 8'hFF);
    #1 chk({7'h00, host_irq}, 8'h00);
    hrd(CAF_HOFS_STATUS, d);
    chk(d & 8'h02, 8'h02);
    hwr(CAF_HOFS_MASK, 8'h00);
    repeat (QC + 10) @(posedge clock_i);
    drd(CAF_OFS_FOS_FLAGS, d);
    chk(d, 8'h00);
    chk({6'h00, cken_o, host_irq}, 8'h02);
    finish_test();
  end
endmodule
`default_nettype wire
